// ### rtl/i2c_seq.sv
// i2c bus master sequencer with apb register file
// assumes open-drain pads with pull-ups outside; one 20 MHz clock
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`include "i2c_seq_consts.svh"

// Operation
// - start and busy work only when enabled
// - disable returns all registers but the mode register to reset
// - speed bit picks standard or fast
// - two-bit field slows bit rate by steps
// - sync bit enables scl stretching wait
// - busy set on start, cleared on stop
// - busy also follows other masters' starts
// - ack level captured after every byte
// - driven versus read sda mismatch flags error
// - sync on: error releases sda until byte end
// - sync off: keep driving despite error
// - control write clears error flag unless a mismatch comes in the same cycle
// - start from idle makes start condition
// - restart plus start makes repeated start
// - address byte msb first, ack, wait
// - data byte msb first, ack, wait
// - shifted out byte lands in receive byte
// - receive samples on scl rise, drives ack
// - receive loads byte, records driven ack
// - wait state entry raises interrupt pulse
// - wait: start, stop or repeated start
// - address bit zero selects direction
// - control bit seven picks ack level
// - after stop: interrupt, start bit cleared
module i2c_seq #(
   parameter int ADDR_W = 18
) (
   // clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rstn,
   // apb slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [ADDR_W-1:0]       paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   // bus lines
   input  wire i2c_seq_pkg::line_pair_t line_in,
   output i2c_seq_pkg::line_pair_t      line_out,
   output i2c_seq_pkg::line_pair_t      line_oe_n,
   // event
   output logic                         iface_interrupt
);
   import i2c_seq_pkg::*;

   if (ADDR_W < 18) begin : g_chk
      $error("ADDR_W must be at least 18");
   end

   line_pair_t ln_s1_ff, ln_s2_ff, ln_prev_ff;
   logic [4:0] mod_ff;
   logic [7:0] sa_ff, td_ff, rd_ff, sh_ff, tmr_ff;
   logic [7:0] low_cnt, high_cnt, hd_cnt;
   logic [3:0] bit_ff;
   logic [1:0] step_ff;
   logic       ack_lvl_ff, st_ff, busy_ff, acr_ff, err_ff;
   logic       addr_ph_ff, rx_ff, scl_low_ff, sda_low_ff, err_hold_ff, irq_ff;
   logic       en, sync_on, acc, wr, wr_con, hit, err_evt, drv_bit;
   logic       cmd_st, cmd_sp, cmd_rs, cmd_kill, line_hi;
   logic [15:0] idx;
   seq_state_t state_ff;

   assign en      = mod_ff[`MOD_EN];
   assign sync_on = mod_ff[`MOD_SYNC];
   assign idx     = paddr[17:2];
   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign hit     = (idx >= `IDX_RECEIVE_BYTE) && (idx <= `IDX_BUS_STATE) &&
                    (paddr[1:0] == 2'h0) && ((paddr >> 18) == '0);
   assign wr_con  = wr && hit && (idx == `IDX_XFER_CONTROL);
   assign cmd_st  = wr_con & pwdata[`CON_ST] & en;
   assign cmd_rs  = cmd_st & pwdata[`CON_RS] & st_ff;
   assign cmd_sp  = wr_con & pwdata[`CON_SP] & st_ff & en;
   assign cmd_kill = wr_con & ~pwdata[`CON_ST] & ~pwdata[`CON_SP] & st_ff;
   assign pready  = 1'b1;
   assign pslverr = acc & ~hit;

   // synchroniser: second stage and later only are read
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         ln_s1_ff   <= '1;
         ln_s2_ff   <= '1;
         ln_prev_ff <= '1;
      end else begin
         ln_s1_ff   <= line_in;
         ln_s2_ff   <= ln_s1_ff;
         ln_prev_ff <= ln_s2_ff;
      end
   end

   // bit timing from mode register
   always_comb begin
      if (!mod_ff[`MOD_SPD]) begin
         low_cnt  = `STD_LOW_BASE + `STD_STEP * {6'h00, mod_ff[3:2]};
         high_cnt = `STD_HIGH_BASE + `STD_STEP * {6'h00, mod_ff[3:2]};
         hd_cnt   = `STD_HD_DAT;
      end else begin
         hd_cnt = `FAST_HD_DAT;
         case (mod_ff[3:2])
            2'h0: begin
               low_cnt  = `FAST_LOW0;
               high_cnt = `FAST_HIGH0;
            end
            2'h1: begin
               low_cnt  = `FAST_LOW1;
               high_cnt = `FAST_HIGH1;
            end
            2'h2: begin
               low_cnt  = `FAST_LOW2;
               high_cnt = `FAST_HIGH2;
            end
            default: begin
               low_cnt  = `FAST_LOW3;
               high_cnt = `FAST_HIGH3;
            end
         endcase
      end
   end

   // registered read data, taken in the setup cycle
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         case (idx)
            `IDX_RECEIVE_BYTE:   prdata <= {24'h000000, rd_ff};
            `IDX_TARGET_ADDRESS: prdata <= {24'h000000, sa_ff};
            `IDX_TRANSMIT_BYTE:  prdata <= {24'h000000, td_ff};
            `IDX_XFER_CONTROL:   prdata <= {24'h000000, ack_lvl_ff, 6'h00, st_ff};
            `IDX_BUS_MODE:       prdata <= {27'h0000000, mod_ff};
            `IDX_BUS_STATE:      prdata <= {29'h00000000, err_ff, acr_ff, busy_ff};
            default:             prdata <= 32'h0000_0000;
         endcase
      end
   end

   // software-owned registers
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         mod_ff <= 5'h00;
      end else if (wr && hit && idx == `IDX_BUS_MODE) begin
         mod_ff <= pwdata[4:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn || !en) begin
         sa_ff      <= `REG_RESET;
         td_ff      <= `REG_RESET;
         ack_lvl_ff <= 1'b0;
      end else if (wr && hit) begin
         if (idx == `IDX_TARGET_ADDRESS)
            sa_ff <= pwdata[7:0];
         if (idx == `IDX_TRANSMIT_BYTE)
            td_ff <= pwdata[7:0];
         if (idx == `IDX_XFER_CONTROL)
            ack_lvl_ff <= pwdata[`CON_ACK];
      end
   end

   // bus busy from start and stop seen on the lines, ours or others
   always_ff @(posedge core_clk) begin
      if (!rstn || !en) begin
         busy_ff <= 1'b0;
      end else if (ln_prev_ff.scl && ln_s2_ff.scl) begin
         if (ln_prev_ff.sda && !ln_s2_ff.sda)
            busy_ff <= 1'b1;
         else if (!ln_prev_ff.sda && ln_s2_ff.sda)
            busy_ff <= 1'b0;
      end
   end

   // error flag: a mismatch in the clear cycle still sets it
   always_ff @(posedge core_clk) begin
      if (!rstn || !en) begin
         err_ff <= 1'b0;
      end else if (err_evt) begin
         err_ff <= 1'b1;
      end else if (wr_con) begin
         err_ff <= 1'b0;
      end
   end

   // level the device drives for the current bit
   always_comb begin
      if (bit_ff == 4'h8)
         drv_bit = rx_ff & ~addr_ph_ff ? ack_lvl_ff : 1'b1;
      else if (rx_ff && !addr_ph_ff)
         drv_bit = 1'b1;
      else if (err_hold_ff && sync_on)
         drv_bit = 1'b1;
      else
         drv_bit = sh_ff[7];
   end

   assign line_hi = ~sync_on | ln_s2_ff.scl;
   assign err_evt = (state_ff == S_XFER) && step_ff == 2'h1 && line_hi &&
                    tmr_ff == 8'h00 && bit_ff != 4'h8 &&
                    (addr_ph_ff || !rx_ff) && sda_low_ff == ln_s2_ff.sda;

   // sequencer
   always_ff @(posedge core_clk) begin
      if (!rstn || !en) begin
         state_ff    <= S_IDLE;
         step_ff     <= 2'h0;
         bit_ff      <= 4'h0;
         tmr_ff      <= 8'h00;
         sh_ff       <= 8'h00;
         rd_ff       <= `REG_RESET;
         acr_ff      <= 1'b0;
         st_ff       <= 1'b0;
         addr_ph_ff  <= 1'b0;
         rx_ff       <= 1'b0;
         scl_low_ff  <= 1'b0;
         sda_low_ff  <= 1'b0;
         err_hold_ff <= 1'b0;
         irq_ff      <= 1'b0;
      end else begin
         irq_ff <= 1'b0;
         if (err_evt && sync_on)
            err_hold_ff <= 1'b1;
         if (cmd_kill) begin
            // forced stop: let go of both lines at once
            state_ff   <= S_IDLE;
            st_ff      <= 1'b0;
            scl_low_ff <= 1'b0;
            sda_low_ff <= 1'b0;
         end else begin
            case (state_ff)
               S_IDLE: begin
                  if (cmd_st && !st_ff) begin
                     st_ff      <= 1'b1;
                     sda_low_ff <= 1'b1;
                     tmr_ff     <= 8'h00;
                     state_ff   <= S_START;
                  end
               end
               S_START: begin
                  tmr_ff <= tmr_ff + 8'h01;
                  if (tmr_ff == high_cnt - 8'h01) begin
                     scl_low_ff <= 1'b1;
                     addr_ph_ff <= 1'b1;
                     sh_ff      <= sa_ff;
                     bit_ff     <= 4'h0;
                     step_ff    <= 2'h0;
                     tmr_ff     <= 8'h00;
                     state_ff   <= S_XFER;
                  end
               end
               S_RSTART: begin
                  case (step_ff)
                     2'h0: begin
                        sda_low_ff <= 1'b0;
                        tmr_ff     <= tmr_ff + 8'h01;
                        if (tmr_ff == hd_cnt) begin
                           scl_low_ff <= 1'b0;
                           tmr_ff     <= 8'h00;
                           step_ff    <= 2'h1;
                        end
                     end
                     2'h1: begin
                        if (line_hi) begin
                           tmr_ff <= tmr_ff + 8'h01;
                           if (tmr_ff == low_cnt - 8'h01) begin
                              sda_low_ff <= 1'b1;
                              tmr_ff     <= 8'h00;
                              state_ff   <= S_START;
                           end
                        end
                     end
                     default: step_ff <= 2'h0;
                  endcase
               end
               S_XFER: begin
                  if (step_ff == 2'h0) begin
                     tmr_ff <= tmr_ff + 8'h01;
                     if (tmr_ff == hd_cnt - 8'h01)
                        sda_low_ff <= ~drv_bit;
                     if (tmr_ff == low_cnt - 8'h01) begin
                        scl_low_ff <= 1'b0;
                        tmr_ff     <= 8'h00;
                        step_ff    <= 2'h1;
                     end
                  end else if (line_hi) begin
                     tmr_ff <= tmr_ff + 8'h01;
                     if (tmr_ff == 8'h00) begin
                        if (bit_ff != 4'h8)
                           sh_ff <= {sh_ff[6:0], ln_s2_ff.sda};
                        else if (rx_ff && !addr_ph_ff)
                           acr_ff <= ack_lvl_ff;
                        else
                           acr_ff <= ln_s2_ff.sda;
                     end
                     if (tmr_ff == high_cnt - 8'h01) begin
                        scl_low_ff <= 1'b1;
                        tmr_ff     <= 8'h00;
                        step_ff    <= 2'h0;
                        if (bit_ff == 4'h8) begin
                           rd_ff       <= sh_ff;
                           err_hold_ff <= 1'b0;
                           irq_ff      <= 1'b1;
                           state_ff    <= S_WAIT;
                        end else begin
                           bit_ff <= bit_ff + 4'h1;
                        end
                     end
                  end
               end
               S_WAIT: begin
                  tmr_ff <= 8'h00;
                  step_ff <= 2'h0;
                  if (tmr_ff == 8'h00 && step_ff == 2'h0 && !cmd_st && !cmd_sp)
                     sda_low_ff <= 1'b0;
                  if (cmd_rs) begin
                     state_ff <= S_RSTART;
                  end else if (cmd_sp) begin
                     sda_low_ff <= 1'b1;
                     state_ff   <= S_STOP;
                  end else if (cmd_st) begin
                     addr_ph_ff <= 1'b0;
                     rx_ff      <= sa_ff[`SA_DIR];
                     sh_ff      <= td_ff;
                     bit_ff     <= 4'h0;
                     state_ff   <= S_XFER;
                  end
               end
               S_STOP: begin
                  case (step_ff)
                     2'h0: begin
                        sda_low_ff <= 1'b1;
                        tmr_ff     <= tmr_ff + 8'h01;
                        if (tmr_ff == low_cnt - 8'h01) begin
                           scl_low_ff <= 1'b0;
                           tmr_ff     <= 8'h00;
                           step_ff    <= 2'h1;
                        end
                     end
                     2'h1: begin
                        if (line_hi) begin
                           tmr_ff <= tmr_ff + 8'h01;
                           if (tmr_ff == high_cnt - 8'h01) begin
                              sda_low_ff <= 1'b0;
                              tmr_ff     <= 8'h00;
                              step_ff    <= 2'h2;
                           end
                        end
                     end
                     default: begin
                        tmr_ff <= tmr_ff + 8'h01;
                        if (tmr_ff == low_cnt - 8'h01) begin
                           st_ff    <= 1'b0;
                           irq_ff   <= 1'b1;
                           step_ff  <= 2'h0;
                           tmr_ff   <= 8'h00;
                           state_ff <= S_IDLE;
                        end
                     end
                  endcase
               end
               default: state_ff <= S_IDLE;
            endcase
         end
      end
   end

   // open drain: the output value is always low
   assign line_out        = '0;
   assign line_oe_n.scl   = ~scl_low_ff;
   assign line_oe_n.sda   = ~sda_low_ff;
   assign iface_interrupt = irq_ff;

   busy_needs_en_a: assert property (@(posedge core_clk) disable iff (!rstn)
      !en |=> !busy_ff && !st_ff)
      else $error("busy or start set while disabled");

   disable_clears_a: assert property (@(posedge core_clk) disable iff (!rstn)
      !en |=> !err_ff && !acr_ff && rd_ff == 8'h00 && state_ff == S_IDLE)
      else $error("disable did not clear state");

   err_sets_a: assert property (@(posedge core_clk) disable iff (!rstn)
      err_evt && en |=> err_ff)
      else $error("mismatch did not flag error");

   ctrl_clears_err_a: assert property (@(posedge core_clk) disable iff (!rstn)
      wr_con && !err_evt |=> !err_ff)
      else $error("control write left error set");

   sync_release_a: assert property (@(posedge core_clk) disable iff (!rstn)
      err_hold_ff && sync_on && state_ff == S_XFER && step_ff == 2'h0 &&
      bit_ff != 4'h8 && tmr_ff == hd_cnt - 8'h01 ##1 en |-> line_oe_n.sda)
      else $error("sda driven after error with sync on");

   wait_irq_a: assert property (@(posedge core_clk) disable iff (!rstn)
      en && state_ff == S_WAIT && $past(state_ff) == S_XFER |-> irq_ff)
      else $error("no interrupt on wait entry");

   rx_ack_rec_a: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(state_ff == S_WAIT) && rx_ff && !addr_ph_ff && en |->
      acr_ff == ack_lvl_ff && rd_ff == $past(sh_ff))
      else $error("receive ack or byte not recorded");

   stop_done_a: assert property (@(posedge core_clk) disable iff (!rstn)
      en && state_ff == S_IDLE && $past(state_ff) == S_STOP && !$past(cmd_kill) |->
      !st_ff && irq_ff)
      else $error("stop did not clear start or interrupt");

   start_seq_a: assert property (@(posedge core_clk) disable iff (!rstn)
      state_ff == S_IDLE && cmd_st && !st_ff && !cmd_kill |=>
      state_ff == S_START && !line_oe_n.sda && line_oe_n.scl)
      else $error("start condition not begun");
endmodule

// ### rtl/i2c_seq_consts.svh
// register indices, field positions, reset values and bit timing counts
// assumes the includer maps byte address = 4 * index on a 32-bit bus
`ifndef I2C_SEQ_CONSTS_SVH
`define I2C_SEQ_CONSTS_SVH

`define IDX_RECEIVE_BYTE   16'hF2A0
`define IDX_TARGET_ADDRESS 16'hF2A1
`define IDX_TRANSMIT_BYTE  16'hF2A2
`define IDX_XFER_CONTROL   16'hF2A3
`define IDX_BUS_MODE       16'hF2A4
`define IDX_BUS_STATE      16'hF2A5
`define REG_RESET          8'h00

`define MOD_EN    0
`define MOD_SPD   1
`define MOD_DW_LO 2
`define MOD_DW_HI 3
`define MOD_SYNC  4
`define CON_ST    0
`define CON_SP    1
`define CON_RS    2
`define CON_ACK   7
`define STAT_BB   0
`define STAT_ACR  1
`define STAT_ER   2
`define SA_DIR    0

// counts in core clock periods
`define STD_LOW_BASE  8'h2C
`define STD_HIGH_BASE 8'h24
`define STD_STEP      8'h04
`define STD_HD_DAT    8'h08
`define FAST_HD_DAT   8'h04
`define FAST_LOW0     8'h0C
`define FAST_LOW1     8'h0E
`define FAST_LOW2     8'h0E
`define FAST_LOW3     8'h10
`define FAST_HIGH0    8'h08
`define FAST_HIGH1    8'h08
`define FAST_HIGH2    8'h0A
`define FAST_HIGH3    8'h0A

`endif

// ### rtl/i2c_seq_pkg.sv
// types shared by the bus sequencer and its bench
// no assumptions beyond a SystemVerilog compiler
package i2c_seq_pkg;
   typedef struct packed {
      logic scl;
      logic sda;
   } line_pair_t;

   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_START  = 3'b001,
      S_RSTART = 3'b010,
      S_XFER   = 3'b011,
      S_WAIT   = 3'b100,
      S_STOP   = 3'b101
   } seq_state_t;
endpackage

// ### testbench/i2c_target_model.sv
// behavioural i2c target: acks its own address, serves one fixed byte on reads
// assumes wired-and lines with pull-ups built by the bench
`timescale 1ns/100ps
module i2c_target_model #(
   parameter logic [6:0] OWN_ADDR = 7'h2A
) (
   // bus lines
   input  wire logic       scl,
   input  wire logic       sda,
   // data
   input  wire logic [7:0] tx_byte,
   output logic            sda_oe_n,
   output logic [7:0]      got_byte
);
   logic [7:0] sh;
   logic       first;
   logic       rd_mode;
   logic       ack_seen;
   int         bitn;
   initial begin
      sda_oe_n = 1'b1;
      got_byte = 8'h00;
      sh = 8'h00;
      first = 1'b1;
      rd_mode = 1'b0;
      ack_seen = 1'b1;
      bitn = 0;
   end
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         bitn = 0;
         first = 1'b1;
         rd_mode = 1'b0;
         sda_oe_n <= 1'b1;
      end
   end
   always @(posedge scl) begin
      if (bitn < 8) begin
         sh = {sh[6:0], sda};
      end else begin
         ack_seen = sda;
      end
      bitn = bitn + 1;
   end
   // data only changes while scl is low
   always @(negedge scl) begin
      if (bitn == 9) begin
         bitn = 0;
         got_byte = sh;
         if (first) begin
            rd_mode = sh[0] && sh[7:1] == OWN_ADDR;
         end else if (ack_seen) begin
            // a nack ends a read: let go of sda so a restart can be made
            rd_mode = 1'b0;
         end
         first = 1'b0;
      end
      if (bitn == 8) begin
         sda_oe_n <= rd_mode || (first && sh[7:1] != OWN_ADDR);
      end else if (rd_mode) begin
         sda_oe_n <= tx_byte[7 - bitn];
      end else begin
         sda_oe_n <= 1'b1;
      end
   end
endmodule

// ### testbench/testbench.sv
// self-checking bench for the i2c sequencer: apb master, target model, bus monitor
// assumes the design package and constants header are compiled first
`timescale 1ns/100ps
`include "i2c_seq_consts.svh"
module testbench;
   import i2c_seq_pkg::*;
   logic              core_clk;
   logic              rstn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [17:0]       paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              iface_interrupt;
   logic              tb_sda_low;
   logic              t_oe_n;
   logic              err_seen;
   logic [7:0]        got_byte;
   logic [7:0]        rd;
   line_pair_t        line_in;
   line_pair_t        line_out;
   line_pair_t        line_oe_n;
   wire logic         scl_w = line_oe_n.scl;
   wire logic         sda_w = line_oe_n.sda & t_oe_n & !tb_sda_low;
   int                err_total;
   int                n_checks;
   int                sda_pulls;
   logic [7:0]        f_lo [4] = '{8'h0C, 8'h0E, 8'h0E, 8'h10};
   logic [7:0]        f_hi [4] = '{8'h08, 8'h08, 8'h0A, 8'h0A};
   assign line_in = {scl_w, sda_w};
   i2c_seq #(.ADDR_W(18)) dut (.core_clk(core_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .line_in(line_in), .line_out(line_out),
      .line_oe_n(line_oe_n), .iface_interrupt(iface_interrupt));
   i2c_target_model target (.scl(scl_w), .sda(sda_w), .tx_byte(8'hC3), .sda_oe_n(t_oe_n),
      .got_byte(got_byte));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      if (err_total == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata[7:0];
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp, input string what);
      apb(1'b0, idx, 8'h00);
      chk(what, rd, exp);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      sda_pulls = 0;
      // sampled mid-cycle so registered outputs have settled
      do begin
         @(negedge core_clk);
         n++;
         if (line_oe_n.sda === 1'b0) sda_pulls++;
      end while (iface_interrupt !== 1'b1 && n < 4000);
      chk("interrupt", {7'h00, iface_interrupt}, 8'h01);
      @(negedge core_clk);
      chk("interrupt pulse", {7'h00, iface_interrupt}, 8'h00);
   endtask
   task automatic t_regs();
      for (int i = 0; i < 6; i++) begin
         rd_chk(16'(`IDX_RECEIVE_BYTE + i), `REG_RESET, "reset value");
      end
      apb(1'b0, 16'h0000, 8'h00);
      chk("unmapped error", {7'h00, err_seen}, 8'h01);
      apb(1'b1, `IDX_XFER_CONTROL, 8'h01);
      rd_chk(`IDX_XFER_CONTROL, 8'h00, "start while off");
      apb(1'b1, `IDX_BUS_MODE, 8'hFE);
      rd_chk(`IDX_BUS_MODE, 8'h1E, "mode bits");
   endtask
   task automatic t_other();
      for (int e = 0; e < 2; e++) begin
         apb(1'b1, `IDX_BUS_MODE, {7'h00, e[0]});
         tb_sda_low <= 1'b1;
         repeat (8) @(posedge core_clk);
         rd_chk(`IDX_BUS_STATE, {7'h00, e[0]}, "foreign start");
         tb_sda_low <= 1'b0;
         repeat (8) @(posedge core_clk);
         rd_chk(`IDX_BUS_STATE, 8'h00, "foreign stop");
      end
      apb(1'b1, `IDX_TARGET_ADDRESS, 8'h77);
      tb_sda_low <= 1'b1;
      repeat (8) @(posedge core_clk);
      apb(1'b1, `IDX_BUS_MODE, 8'h00);
      rd_chk(`IDX_TARGET_ADDRESS, 8'h00, "address after disable");
      rd_chk(`IDX_BUS_STATE, 8'h00, "state after disable");
      tb_sda_low <= 1'b0;
   endtask
   task automatic t_timing();
      int lo;
      int hi;
      for (int m = 0; m < 8; m++) begin
         apb(1'b1, `IDX_BUS_MODE, {4'h0, m[1:0], m[2], 1'b1});
         apb(1'b1, `IDX_TARGET_ADDRESS, 8'h10);
         apb(1'b1, `IDX_XFER_CONTROL, 8'h01);
         @(negedge scl_w);
         @(negedge scl_w);
         lo = 0;
         hi = 0;
         // count on the falling clock edge, away from the launching edge
         @(negedge core_clk);
         while (scl_w === 1'b0) begin
            lo++;
            @(negedge core_clk);
         end
         while (scl_w === 1'b1) begin
            hi++;
            @(negedge core_clk);
         end
         chk("scl low", 8'(lo), m[2] ? f_lo[m[1:0]] : 8'(44 + 4 * m[1:0]));
         chk("scl high", 8'(hi), m[2] ? f_hi[m[1:0]] : 8'(36 + 4 * m[1:0]));
         wait_irq();
         rd_chk(`IDX_BUS_STATE, 8'h03, "nack state");
         apb(1'b1, `IDX_XFER_CONTROL, 8'h02);
         wait_irq();
      end
   endtask
   task automatic t_write();
      apb(1'b1, `IDX_BUS_MODE, 8'h13);
      apb(1'b1, `IDX_TARGET_ADDRESS, 8'h54);
      apb(1'b1, `IDX_TRANSMIT_BYTE, 8'hA5);
      apb(1'b1, `IDX_XFER_CONTROL, 8'h01);
      wait_irq();
      rd_chk(`IDX_BUS_STATE, 8'h01, "state after address");
      rd_chk(`IDX_RECEIVE_BYTE, 8'h54, "address echo");
      apb(1'b1, `IDX_XFER_CONTROL, 8'h01);
      wait_irq();
      chk("target byte", got_byte, 8'hA5);
      rd_chk(`IDX_RECEIVE_BYTE, 8'hA5, "data echo");
      rd_chk(`IDX_XFER_CONTROL, 8'h01, "start held");
      apb(1'b1, `IDX_XFER_CONTROL, 8'h02);
      wait_irq();
      rd_chk(`IDX_XFER_CONTROL, 8'h00, "start after stop");
      rd_chk(`IDX_BUS_STATE, 8'h00, "state after stop");
   endtask
   task automatic t_read();
      apb(1'b1, `IDX_TARGET_ADDRESS, 8'h55);
      apb(1'b1, `IDX_XFER_CONTROL, 8'h01);
      wait_irq();
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, `IDX_XFER_CONTROL, {k[0], 6'h00, 1'b1});
         wait_irq();
         rd_chk(`IDX_RECEIVE_BYTE, 8'hC3, "received byte");
         rd_chk(`IDX_BUS_STATE, {6'h00, k[0], 1'b1}, "driven ack");
      end
      apb(1'b1, `IDX_TARGET_ADDRESS, 8'h54);
      apb(1'b1, `IDX_XFER_CONTROL, 8'h05);
      wait_irq();
      chk("address after restart", got_byte, 8'h54);
      rd_chk(`IDX_BUS_STATE, 8'h01, "ack after restart");
      apb(1'b1, `IDX_XFER_CONTROL, 8'h02);
      wait_irq();
   endtask
   task automatic t_error();
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, `IDX_BUS_MODE, {3'b000, s[0], 4'b0011});
         apb(1'b1, `IDX_TARGET_ADDRESS, 8'hFE);
         apb(1'b1, `IDX_XFER_CONTROL, 8'h01);
         @(negedge scl_w);
         repeat (8) @(posedge core_clk);
         // pull sda under a released bit from scl low through the scl high phase until just after the next scl fall
         tb_sda_low <= 1'b1;
         @(negedge scl_w);
         repeat (2) @(posedge core_clk);
         tb_sda_low <= 1'b0;
         wait_irq();
         chk("sda driven after error", {7'h00, sda_pulls > 0}, {7'h00, !s[0]});
         rd_chk(`IDX_BUS_STATE, 8'h07, "error state");
         apb(1'b1, `IDX_XFER_CONTROL, 8'h02);
         wait_irq();
         apb(1'b0, `IDX_BUS_STATE, 8'h00);
         chk("error cleared", rd & 8'h05, 8'h00);
      end
   endtask
   always @(posedge core_clk) begin
      if (rstn === 1'b1) chk("line out", {6'h00, line_out}, 8'h00);
   end
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      repeat (60000) @(posedge core_clk);
      err_total++;
      stop_test();
   end
   initial begin
      err_total = 0;
      n_checks = 0;
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 18'h00000;
      pwdata = 32'h00000000;
      tb_sda_low = 1'b0;
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_regs();
      t_other();
      t_timing();
      t_write();
      t_read();
      t_error();
      stop_test();
   end
endmodule
